// >>> design/pso_consts.vh
/*
 * Constants of the power-stage output configuration block: register
 * offsets, field positions, reset values and interrupt vector numbers.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PSO_CONSTS_VH
`define PSO_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSO_OFS_SOC0     8'h00
`define PSO_OFS_SOC1     8'h04
`define PSO_OFS_SOC2     8'h08
`define PSO_OFS_CNF0     8'h0c
`define PSO_OFS_CNF1     8'h10
`define PSO_OFS_CNF2     8'h14
`define PSO_OFS_STATUS   8'h80
`define PSO_OFS_IRQ_EN   8'h84
`define PSO_OFS_IRQ_CLR  8'h88
// Compare block: unit u at (u+1)*0x20, reg k at k*8, high byte at +4
`define PSO_CMP_STRIDE   8'h20
`define PSO_CMP_SA       2'h0
`define PSO_CMP_RA       2'h1
`define PSO_CMP_SB       2'h2
`define PSO_CMP_RB       2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSO_B_EN_A       0
`define PSO_B_EN_C       1
`define PSO_B_EN_B       2
`define PSO_B_EN_D       3
`define PSO_B_SYNC_LO    4
`define PSO_B_SEL_C      6
`define PSO_B_SEL_D      7
`define PSO_B_MODE_LO    3
`define PSO_SOC01_MASK   8'h35
`define PSO_MODE_CENTER  2'h3
`define PSO_SYNC_LEAD_A  2'h0
`define PSO_SYNC_TRAIL_A 2'h1
`define PSO_SYNC_LEAD_B  2'h2
`define PSO_SYNC_TRAIL_B 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSO_RST_CFG      8'h00
`define PSO_RST_CMP      12'h000
`define PSO_RST_RB       16'h0000
`define PSO_RST_IRQ      6'h00
// Counter parked on a value out of reset is no event
`define PSO_RST_MATCH    12'hfff

// ----------------------------------------
// Interrupt vectors: status bit k is vector address k+1
// ----------------------------------------
`define PSO_VEC_NONE     4'h0

`endif

// >>> design/pso_top.v
/*
 * Configuration side of three 12-bit power-stage PWM units: pin enables,
 * extra output selection, ADC sync pulse, compare registers with shared
 * high-byte latch, and per-unit capture / end-of-cycle interrupts.
 * Assumes counters, generators and event sources run on pclk.
 */
// Our own choices: the APB interface to the registers and the register addresses.
// Summary of operation
// [RQ1] Two irq requests per unit, vectors 1..6
// [RQ2] Units identical; unit 2 adds extra outputs
// [RQ3] Bit 7 selects B or A for fourth
// [RQ4] Bit 6 selects A or B for third
// [RQ5] Ramp modes: sync select picks edge source
// [RQ6] Trailing edge also on fault or retrigger; code ORs in fault only, not retrigger
// [RQ7] Centred: reset-A match down or up only
// [RQ8] Software keeps reset-A value at least one
// [RQ9] Bit 0 hands pin A to generator
// [RQ10] Bit 2 hands pin B to generator
// [RQ11] Unit 2 bit 1 hands third pin
// [RQ12] Unit 2 bit 3 hands fourth pin
// [RQ13] Four 12-bit compares against counter
// [RQ14] Matches feed interrupt or waveform
// [RQ15] Reset-B holds 4-bit flank modulation
// [RQ16] Shared high-byte latch, both bytes together
// [RQ17] High byte first; low write commits
// [RQ18] End-of-cycle flag on reset-B match
// [RQ19] Capture flag on retrigger, capture, sync error
`timescale 1ns/100ps
`include "pso_consts.vh"

module pso_top (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Counter side, unit u in slice u
	input  wire [35:0] cnt_val,
	input  wire [2:0]  cnt_down,
	input  wire [2:0]  gen_a,
	input  wire [2:0]  gen_b,
	input  wire [2:0]  fault_a,
	input  wire [2:0]  fault_b,
	input  wire [2:0]  retrig_evt,
	input  wire [2:0]  capture_evt,
	input  wire [2:0]  sync_err,
	// Ordinary port drive: A0 B0 A1 B1 A2 B2 third fourth
	input  wire [7:0]  port_o,
	input  wire [7:0]  port_oe,
	// Pins
	output reg  [7:0]  pin_o,
	output reg  [7:0]  pin_oe,
	// Compare results to generators
	output reg  [11:0] cmp_match,
	output reg  [11:0] fwm_val,
	output reg  [2:0]  adc_trigger,
	// Interrupts
	output reg  [5:0]  irq_req,
	output reg  [3:0]  irq_vec,
	output reg         irq
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0]  soc_r [0:2];
	reg  [7:0]  cnf_r [0:2];
	reg  [11:0] sa_r  [0:2];
	reg  [11:0] ra_r  [0:2];
	reg  [11:0] sb_r  [0:2];
	reg  [15:0] rb_r  [0:2];
	reg  [7:0]  hi_r;
	reg  [11:0] match_d_r;
	reg  [5:0]  sts_r;
	reg  [5:0]  ien_r;

	reg  [11:0] now_nxt;
	reg  [11:0] ev_nxt;
	reg  [2:0]  adc_nxt;
	reg  [5:0]  set_nxt;
	reg  [5:0]  sts_nxt;
	reg  [7:0]  pin_nxt;
	reg  [7:0]  oe_nxt;
	reg  [3:0]  vec_nxt;
	reg  [31:0] rd_nxt;
	reg  [11:0] cv;
	reg  [1:0]  sel;
	reg         ctr;
	reg         dn;
	integer     u;
	integer     k;
	integer     r;

	wire        acc = psel & penable & pready;
	wire        wr  = acc & pwrite;
	wire [5:0]  clr = (wr && paddr == `PSO_OFS_IRQ_CLR) ? pwdata[5:0] : 6'h00;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Compare window unit index, 3 when outside
	function [1:0] cmp_unit;
		input [7:0] a;
		begin
			if (a[7] == 1'b0 && a[6:5] != 2'h0 && a[1:0] == 2'h0)
				cmp_unit = a[6:5] - 2'h1;
			else
				cmp_unit = 2'h3;
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			case (a)
				`PSO_OFS_SOC0, `PSO_OFS_SOC1, `PSO_OFS_SOC2,
				`PSO_OFS_CNF0, `PSO_OFS_CNF1, `PSO_OFS_CNF2,
				`PSO_OFS_STATUS, `PSO_OFS_IRQ_EN, `PSO_OFS_IRQ_CLR:
					mapped = 1'b1;
				default:
					mapped = (cmp_unit(a) != 2'h3);
			endcase
		end
	endfunction

	// Status bit of a unit's request: unit 2 lowest vector
	function [2:0] irq_bit;
		input [1:0] unit;
		input       eoc;
		begin
			irq_bit = {(2'h2 - unit), eoc};
		end
	endfunction

	wire [1:0] wu = cmp_unit(paddr);

	// ----------------------------------------
	// Compare, sync and pin logic
	// ----------------------------------------
	always @* begin
		now_nxt = 12'h000;
		adc_nxt = 3'h0;
		set_nxt = 6'h00;
		pin_nxt = 8'h00;
		oe_nxt  = 8'h00;
		cv      = 12'h000;
		sel     = 2'h0;
		ctr     = 1'b0;
		dn      = 1'b0;
		for (u = 0; u < 3; u = u + 1) begin
			cv = cnt_val[12*u +: 12];
			now_nxt[4*u]   = (cv == sa_r[u]);       // [RQ13]
			now_nxt[4*u+1] = (cv == ra_r[u]);
			now_nxt[4*u+2] = (cv == sb_r[u]);
			now_nxt[4*u+3] = (cv == rb_r[u][11:0]);
		end
		// Edge only, so a counter that dwells does not refire
		ev_nxt = now_nxt & ~match_d_r;
		for (u = 0; u < 3; u = u + 1) begin
			sel = soc_r[u][`PSO_B_SYNC_LO +: 2];
			ctr = (cnf_r[u][`PSO_B_MODE_LO +: 2] == `PSO_MODE_CENTER);
			dn  = cnt_down[u];
			if (ctr) begin
				// Reset-A of zero never matches going down [RQ8]
				case (sel)
					`PSO_SYNC_LEAD_A:  adc_nxt[u] = ev_nxt[4*u+1] & dn;  // [RQ7]
					`PSO_SYNC_TRAIL_A: adc_nxt[u] = ev_nxt[4*u+1] & ~dn; // [RQ7]
					default:           adc_nxt[u] = 1'b0;               // [RQ7]
				endcase
			end else begin
				case (sel)
					`PSO_SYNC_LEAD_A:  adc_nxt[u] = ev_nxt[4*u];       // [RQ5]
					`PSO_SYNC_TRAIL_A: adc_nxt[u] = ev_nxt[4*u+1] | fault_a[u]; // [RQ6]
					`PSO_SYNC_LEAD_B:  adc_nxt[u] = ev_nxt[4*u+2];     // [RQ5]
					`PSO_SYNC_TRAIL_B: adc_nxt[u] = ev_nxt[4*u+3] | fault_b[u]; // [RQ6]
					default:           adc_nxt[u] = 1'b0;
				endcase
			end
			set_nxt[irq_bit(u[1:0], 1'b1)] = ev_nxt[4*u+3];          // [RQ18]
			set_nxt[irq_bit(u[1:0], 1'b0)] =
				retrig_evt[u] | capture_evt[u] | sync_err[u];        // [RQ19]
			// Enabled pin follows generator, else the port [RQ9] [RQ10]
			pin_nxt[2*u]   = soc_r[u][`PSO_B_EN_A] ? gen_a[u] : port_o[2*u];
			oe_nxt[2*u]    = soc_r[u][`PSO_B_EN_A] | port_oe[2*u];
			pin_nxt[2*u+1] = soc_r[u][`PSO_B_EN_B] ? gen_b[u] : port_o[2*u+1];
			oe_nxt[2*u+1]  = soc_r[u][`PSO_B_EN_B] | port_oe[2*u+1];
		end
		// Unit 2 extra outputs [RQ2]
		if (soc_r[2][`PSO_B_EN_C]) begin                             // [RQ11]
			pin_nxt[6] = soc_r[2][`PSO_B_SEL_C] ? gen_b[2] : gen_a[2]; // [RQ4]
			oe_nxt[6]  = 1'b1;
		end else begin
			pin_nxt[6] = port_o[6];
			oe_nxt[6]  = port_oe[6];
		end
		if (soc_r[2][`PSO_B_EN_D]) begin                             // [RQ12]
			pin_nxt[7] = soc_r[2][`PSO_B_SEL_D] ? gen_a[2] : gen_b[2]; // [RQ3]
			oe_nxt[7]  = 1'b1;
		end else begin
			pin_nxt[7] = port_o[7];
			oe_nxt[7]  = port_oe[7];
		end
	end

	// ----------------------------------------
	// Interrupt status and vector
	// ----------------------------------------
	always @* begin
		// Set wins over a clear in the same cycle
		sts_nxt = (sts_r & ~clr) | set_nxt;
		vec_nxt = `PSO_VEC_NONE;
		for (k = 5; k >= 0; k = k - 1) begin
			if (sts_nxt[k] & ien_r[k])
				vec_nxt = k[3:0] + 4'h1;                            // [RQ1]
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rd_nxt = 32'h0000_0000;
		case (paddr)
			`PSO_OFS_SOC0:   rd_nxt[7:0] = soc_r[0];
			`PSO_OFS_SOC1:   rd_nxt[7:0] = soc_r[1];
			`PSO_OFS_SOC2:   rd_nxt[7:0] = soc_r[2];
			`PSO_OFS_CNF0:   rd_nxt[7:0] = cnf_r[0];
			`PSO_OFS_CNF1:   rd_nxt[7:0] = cnf_r[1];
			`PSO_OFS_CNF2:   rd_nxt[7:0] = cnf_r[2];
			`PSO_OFS_STATUS: rd_nxt[5:0] = sts_r;
			`PSO_OFS_IRQ_EN: rd_nxt[5:0] = ien_r;
			// Compares are write only and read as zero
			default:         rd_nxt = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// APB handshake: one wait state, answer from flops
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped(paddr);
			if (psel & penable & ~pready & ~pwrite)
				prdata <= rd_nxt;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (r = 0; r < 3; r = r + 1) begin
				soc_r[r] <= `PSO_RST_CFG;
				cnf_r[r] <= `PSO_RST_CFG;
				sa_r[r]  <= `PSO_RST_CMP;
				ra_r[r]  <= `PSO_RST_CMP;
				sb_r[r]  <= `PSO_RST_CMP;
				rb_r[r]  <= `PSO_RST_RB;
			end
			hi_r  <= `PSO_RST_CFG;
			ien_r <= `PSO_RST_IRQ;
		end else if (wr && !pslverr) begin
			case (paddr)
				// Units 0 and 1 lack the extra output bits [RQ2]
				`PSO_OFS_SOC0:   soc_r[0] <= pwdata[7:0] & `PSO_SOC01_MASK;
				`PSO_OFS_SOC1:   soc_r[1] <= pwdata[7:0] & `PSO_SOC01_MASK;
				`PSO_OFS_SOC2:   soc_r[2] <= pwdata[7:0];
				`PSO_OFS_CNF0:   cnf_r[0] <= pwdata[7:0];
				`PSO_OFS_CNF1:   cnf_r[1] <= pwdata[7:0];
				`PSO_OFS_CNF2:   cnf_r[2] <= pwdata[7:0];
				`PSO_OFS_IRQ_EN: ien_r    <= pwdata[5:0];
				default: begin
					if (wu != 2'h3) begin
						if (paddr[2]) begin
							hi_r <= pwdata[7:0];                       // [RQ16]
						end else begin
							// Low byte commits the latched high byte [RQ17]
							case (paddr[4:3])
								`PSO_CMP_SA: sa_r[wu] <= {hi_r[3:0], pwdata[7:0]}; // [RQ16]
								`PSO_CMP_RA: ra_r[wu] <= {hi_r[3:0], pwdata[7:0]};
								`PSO_CMP_SB: sb_r[wu] <= {hi_r[3:0], pwdata[7:0]};
								default:     rb_r[wu] <= {hi_r, pwdata[7:0]}; // [RQ15]
							endcase
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Event, status and output flops
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// All high, so no spurious match or interrupt after reset
			match_d_r   <= `PSO_RST_MATCH;
			sts_r       <= `PSO_RST_IRQ;
			cmp_match   <= 12'h000;
			fwm_val     <= 12'h000;
			adc_trigger <= 3'h0;
			pin_o       <= 8'h00;
			pin_oe      <= 8'h00;
			irq_req     <= `PSO_RST_IRQ;
			irq_vec     <= `PSO_VEC_NONE;
			irq         <= 1'b0;
		end else begin
			match_d_r   <= now_nxt;
			sts_r       <= sts_nxt;
			cmp_match   <= ev_nxt;                                  // [RQ14]
			fwm_val     <= {rb_r[2][15:12], rb_r[1][15:12], rb_r[0][15:12]}; // [RQ15]
			adc_trigger <= adc_nxt;
			pin_o       <= pin_nxt;
			pin_oe      <= oe_nxt;
			irq_req     <= sts_nxt & ien_r;                         // [RQ1]
			irq_vec     <= vec_nxt;
			irq         <= |(sts_nxt & ien_r);
		end
	end

endmodule

// >>> tb/pso_stage_model.sv
/* Sample-and-hold side of the stage: counts conversion triggers of unit 0.
   Assumes triggers are single-cycle pulses on pclk. */
`timescale 1ns/100ps
module pso_stage_model (
	// Clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// Trigger in, conversion count out
	input  wire [2:0] adc_trigger,
	output reg  [7:0] hold_count
);
	// ----------------------------------------
	// Conversion counter
	// ----------------------------------------
	// One sample per pulse; a stuck level would count every cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_count <= 8'h00;
		else if (adc_trigger[0])
			hold_count <= hold_count + 8'h01;
	end
endmodule

// >>> tb/pso_top_sva.sv
/* Checker of the output configuration block: bus handshake, pin hand-over,
   sync pulse causes, interrupt summary. Bound to pso_top by the bench. */
`timescale 1ns/100ps
module pso_top_sva (
	// Clock, reset, bus
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	// Stage side
	input wire [7:0]  port_oe,
	input wire [2:0]  gen_a,
	input wire [2:0]  gen_b,
	input wire [2:0]  fault_a,
	input wire [2:0]  fault_b,
	input wire [7:0]  pin_o,
	input wire [7:0]  pin_oe,
	input wire [11:0] cmp_match,
	input wire [2:0]  adc_trigger,
	// Interrupts
	input wire [5:0]  irq_req,
	input wire [3:0]  irq_vec,
	input wire        irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	chk_err_pair: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_irq_sum: assert property (irq == |irq_req) else $error("irq not sum");
	chk_vec_idle: assert property ((irq_vec == 4'h0) == !irq) else $error("vector idle");
	chk_vec_first: assert property (irq_req[0] |-> irq_vec == 4'h1) else $error("vector 1");
	chk_vec_last: assert property (irq_req == 6'h20 |-> irq_vec == 4'h6) else $error("vector 6");
	chk_match_once: assert property (cmp_match != 12'h000 |=> (cmp_match & $past(cmp_match)) == 12'h000)
		else $error("match repeated");
	chk_sync_cause: assert property (adc_trigger[0] |-> cmp_match[3:0] != 4'h0 || $past(fault_a[0])
		|| $past(fault_b[0])) else $error("sync without cause");
	chk_pin_a_gen: assert property (pin_oe[0] && !$past(port_oe[0]) |-> pin_o[0] == $past(gen_a[0]))
		else $error("pin a source");
	chk_pin_b_gen: assert property (pin_oe[1] && !$past(port_oe[1]) |-> pin_o[1] == $past(gen_b[0]))
		else $error("pin b source");
endmodule

// >>> tb/pso_top_tb.sv
/* Bench of the output configuration block: APB master, counter and event
   stimulus, pin and interrupt checks. Assumes one clock, pclk. */
`timescale 1ns/100ps
module pso_top_tb;
	reg         pclk, presetn, psel, penable, pwrite, err;
	reg  [7:0]  paddr, port_o, port_oe, c, base;
	reg  [31:0] pwdata, rnd, rdv;
	reg  [35:0] cnt_val;
	reg  [2:0]  cnt_down, gen_a, gen_b, fault_a, fault_b, retrig_evt, capture_evt, sync_err;
	wire [31:0] prdata;
	wire        pready, pslverr, irq;
	wire [7:0]  pin_o, pin_oe, hold_count;
	wire [11:0] cmp_match, fwm_val;
	wire [2:0]  adc_trigger;
	wire [5:0]  irq_req;
	wire [3:0]  irq_vec;
	integer     num_errors, total_checks, cycles, i, m, s, d;
	pso_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.cnt_val, .cnt_down, .gen_a, .gen_b, .fault_a, .fault_b, .retrig_evt, .capture_evt, .sync_err,
		.port_o, .port_oe, .pin_o, .pin_oe, .cmp_match, .fwm_val, .adc_trigger, .irq_req, .irq_vec, .irq);
	pso_stage_model PTN (.pclk, .presetn, .adc_trigger, .hold_count);
	always #2 pclk = ~pclk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function [7:0] exp_pins(input [7:0] cf, input ga, input gb, input [3:0] po, input [3:0] poe);
		reg [3:0] en, src;
		begin
			en = {cf[3], cf[1], cf[2], cf[0]};
			src = {cf[7] ? ga : gb, cf[6] ? gb : ga, gb, ga};
			exp_pins = {(en & src) | (~en & po), en | poe};
		end
	endfunction
	function [7:0] exp_sync(input cm, input [1:0] sel, input dn);
		exp_sync = cm ? {7'h00, (sel == 2'h0 && dn) || (sel == 2'h1 && !dn)} : 8'h01 + {7'h00, sel[0]};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input [7:0] a, input w, input [31:0] dat);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= dat;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			rdv = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		begin
			apb(a, 1'b0, 32'h0);
			chk(rdv, exp);
		end
	endtask
	task cmpw(input [7:0] a, input [15:0] v);
		begin
			apb(a + 8'h04, 1'b1, {24'h0, v[15:8]});
			apb(a, 1'b1, {24'h0, v[7:0]});
		end
	endtask
	task sweep(input dn, input flt);
		begin
			@(posedge pclk);
			cnt_down[0] <= dn;
			for (i = 1; i < 6; i = i + 1) begin
				@(posedge pclk);
				cnt_val[11:0] <= i[11:0];
			end
			@(posedge pclk);
			cnt_val[11:0] <= 12'h000;
			{fault_a[0], fault_b[0]} <= {flt, flt};
			@(posedge pclk);
			{fault_a[0], fault_b[0]} <= 2'b00;
			repeat (3) @(posedge pclk);
		end
	endtask
	task evt(input [2:0] cp, input [2:0] rt, input [2:0] se);
		begin
			@(posedge pclk);
			{capture_evt, retrig_evt, sync_err} <= {cp, rt, se};
			@(posedge pclk);
			{capture_evt, retrig_evt, sync_err} <= '0;
			repeat (2) @(posedge pclk);
			#1;
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	always @(posedge pclk) begin
		cycles = cycles + 1;
		if (cycles == 6000) begin
			num_errors = num_errors + 1;
			print_verdict;
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{pclk, psel, penable, pwrite, paddr, pwdata, port_o, port_oe} = '0;
		{cnt_val, cnt_down, gen_a, gen_b, fault_a, fault_b, retrig_evt, capture_evt, sync_err} = '0;
		presetn = 1'b0;
		num_errors = 0;
		total_checks = 0;
		cycles = 0;
		rnd = 32'hd27b2030;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 6; i = i + 1)
			rd(8'h04 * i[7:0], 32'h0);
		rd(8'h84, 32'h0);
		rd(8'hfc, 32'h0);
		chk(err, 1'b1);
		for (i = 0; i < 3; i = i + 1) begin
			rnd = lfsr(rnd);
			apb(8'h04 * i[7:0], 1'b1, rnd);
			rd(8'h04 * i[7:0], (i == 2) ? rnd[7:0] : rnd[7:0] & 8'h35);
		end
		for (i = 0; i < 8; i = i + 1) begin
			rnd = lfsr(rnd);
			c = (i == 0) ? 8'hff : rnd[7:0];
			apb(8'h08, 1'b1, {24'h0, c});
			{gen_a[2], gen_b[2], port_o, port_oe} <= {rnd[8], rnd[9], rnd[23:16], rnd[31:24]};
			repeat (2) @(posedge pclk);
			#1;
			chk({pin_o[7:4], pin_oe[7:4]}, exp_pins(c, rnd[8], rnd[9], rnd[23:20], rnd[31:28]));
		end
		apb(8'h84, 1'b1, 32'h21);
		apb(8'h3c, 1'b1, {24'h0, rnd[7:4], 4'h0});
		#1;
		chk(fwm_val[3:0], 4'h0);
		apb(8'h38, 1'b1, 32'h04);
		@(posedge pclk);
		#1;
		chk(fwm_val[3:0], rnd[7:4]);
		cmpw(8'h20, 16'h0001);
		cmpw(8'h28, 16'h0002);
		cmpw(8'h30, 16'h0003);
		for (m = 0; m < 2; m = m + 1) begin
			apb(8'h0c, 1'b1, m ? 32'h18 : 32'h0);
			for (s = 0; s < 4; s = s + 1)
				for (d = 0; d < 2; d = d + 1) begin
					apb(8'h00, 1'b1, {26'h0, s[1:0], 4'h0});
					base = hold_count;
					sweep(d[0], !m[0]);
					chk(hold_count - base, exp_sync(m[0], s[1:0], d[0]));
				end
		end
		chk({irq, irq_vec}, {1'b1, 4'h6});
		rd(8'h80, 32'h20);
		evt(3'h4, 3'h2, 3'h1);
		chk({irq, irq_vec, irq_req}, {1'b1, 4'h1, 6'h21});
		rd(8'h80, 32'h35);
		apb(8'h88, 1'b1, 32'h3f);
		rd(8'h80, 32'h0);
		apb(8'h84, 1'b1, 32'h0);
		evt(3'h1, 3'h0, 3'h0);
		chk(irq, 1'b0);
		rd(8'h80, 32'h10);
		print_verdict;
	end
endmodule
bind pso_top pso_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .port_oe, .gen_a,
	.gen_b, .fault_a, .fault_b, .pin_o, .pin_oe, .cmp_match, .adc_trigger, .irq_req, .irq_vec, .irq);
